// [core/torque_off_monitor.sv]
`timescale 1ns/1ns
// Summary of operation
// - Both low: tripped, indicator on.
// - Both high: run permitted, indicator off.
// - One high only: tripped, indicator off.
// - Mismatch up to 1.6 s never latches.
// - Mismatch beyond 3.0 s always latches.
// - Latched fault holds trip, indicator off.
// - Only a reset (resetn_in low) leaves latched fault.
// - Low pulses under 2 ms ignored.
// - Low must persist 6 ms to react.
// - Log trip only at start or running.
// - Torque stops 2 to 10 ms after low.
module torque_off_monitor
   import torque_off_pkg::*;
#(
   parameter int unsigned FAULT_TICKS_P = FAULT_TICKS,
   parameter int unsigned TICK_DIV_P = TICK_DIV
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic safety_enable_channel_a_in,
   input wire logic safety_enable_channel_b_in,
   input wire logic start_cmd_in,
   input wire logic running_in,
   output logic run_enable_out,
   output logic torque_off_trip_out,
   output logic safe_state_indicator_out,
   output logic fault_locked_out,
   output logic trip_log_out
);

   // ----------------------------------------------------------------
   // Synchronisers and tick
   // ----------------------------------------------------------------
   logic [1:0] meta_r;
   logic [1:0] sync_r;
   logic [11:0] div_r;
   logic tick_r;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_r <= 2'h0;
         sync_r <= 2'h0;
      end else begin
         meta_r <= {safety_enable_channel_b_in, safety_enable_channel_a_in};
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_r <= 12'h000;
         tick_r <= 1'b0;
      end else if (div_r == 12'(TICK_DIV_P - 1)) begin
         div_r <= 12'h000;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 12'h001;
         tick_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Per-channel low qualification
   // ----------------------------------------------------------------
   // Rising edges pass at once; only a falling level is filtered, so a
   // test pulse cannot trip the drive but recovery is not delayed.
   logic [1:0] chan_r;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_filt
         logic [7:0] low_cnt_r;
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               low_cnt_r <= 8'h00;
               chan_r[g] <= 1'b0;
            end else if (sync_r[g]) begin
               low_cnt_r <= 8'h00;
               chan_r[g] <= 1'b1;
            end else if (tick_r) begin
               if (low_cnt_r >= 8'(QUALIFY_TICKS - 1)) begin
                  chan_r[g] <= 1'b0;
               end else begin
                  low_cnt_r <= low_cnt_r + 8'h01;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Discrepancy timer
   // ----------------------------------------------------------------
   logic [15:0] mis_cnt_r;
   logic mis_done;
   assign mis_done = (mis_cnt_r >= 16'(FAULT_TICKS_P));

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mis_cnt_r <= 16'h0000;
      end else if (chan_r[0] == chan_r[1]) begin
         mis_cnt_r <= 16'h0000;
      end else if (tick_r && !mis_done) begin
         mis_cnt_r <= mis_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   monitor_state_t state_r;
   monitor_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_LOCKED: begin
            state_nxt = ST_LOCKED;
         end
         default: begin
            if (chan_r != 2'b11 && chan_r != 2'b00 && mis_done) begin
               state_nxt = ST_LOCKED;
            end else if (chan_r == 2'b11) begin
               state_nxt = ST_RUN_OK;
            end else if (chan_r == 2'b00) begin
               state_nxt = ST_SAFE;
            end else begin
               state_nxt = ST_MISMATCH;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= ST_SAFE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_enable_out <= 1'b0;
         torque_off_trip_out <= 1'b1;
         safe_state_indicator_out <= 1'b0;
         fault_locked_out <= 1'b0;
      end else begin
         run_enable_out <= (state_nxt == ST_RUN_OK);
         torque_off_trip_out <= (state_nxt != ST_RUN_OK);
         safe_state_indicator_out <= (state_nxt == ST_SAFE);
         fault_locked_out <= (state_nxt == ST_LOCKED);
      end
   end

   // A trip is logged only when it hurts: at a start request or while the
   // motor is running. Stopping through the inputs while idle is normal use.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         trip_log_out <= 1'b0;
      end else begin
         trip_log_out <= (state_nxt != ST_RUN_OK) &&
                         (start_cmd_in || (running_in && state_r == ST_RUN_OK));
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_locked_stays: assert property (@(posedge clk_in) disable iff (!resetn_in)
      state_r == ST_LOCKED |=> state_r == ST_LOCKED)
      else $error("Locked fault state was left.");

   a_locked_outputs: assert property (@(posedge clk_in) disable iff (!resetn_in)
      state_r == ST_LOCKED |=> !run_enable_out && !safe_state_indicator_out)
      else $error("Locked state does not hold trip.");

   a_both_low_safe: assert property (@(posedge clk_in) disable iff (!resetn_in)
      chan_r == 2'b00 && state_r != ST_LOCKED |=> safe_state_indicator_out && torque_off_trip_out)
      else $error("Both low did not give safe state.");

   a_both_high_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
      chan_r == 2'b11 && state_r != ST_LOCKED && !mis_done |=> run_enable_out)
      else $error("Both high did not permit run.");

   a_one_high_trip: assert property (@(posedge clk_in) disable iff (!resetn_in)
      chan_r[0] != chan_r[1] |=> !run_enable_out && !safe_state_indicator_out)
      else $error("Single channel did not trip with indicator off.");

   a_no_early_lock: assert property (@(posedge clk_in) disable iff (!resetn_in)
      $rose(state_r == ST_LOCKED) |-> mis_cnt_r >= 16'(MISMATCH_OK_MS * 1000 / TICK_US))
      else $error("Fault latched too early.");

   // The lock follows from the timer alone, with no further input change.
   sequence s_limit_reached;
      mis_done && chan_r[0] != chan_r[1];
   endsequence

   sequence s_lock_taken;
      ##[1:2] state_r == ST_LOCKED;
   endsequence

   a_lock_by_limit: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_limit_reached |-> s_lock_taken)
      else $error("Fault not latched after limit.");

   a_short_pulse_ignored: assert property (@(posedge clk_in) disable iff (!resetn_in)
      $fell(chan_r[0]) |-> g_filt[0].low_cnt_r >= 8'(PULSE_REJECT_US / TICK_US))
      else $error("Channel dropped before qualification.");

   a_short_pulse_b: assert property (@(posedge clk_in) disable iff (!resetn_in)
      $fell(chan_r[1]) |-> g_filt[1].low_cnt_r >= 8'(PULSE_REJECT_US / TICK_US))
      else $error("Channel B dropped before qualification.");

   a_agree_clears: assert property (@(posedge clk_in) disable iff (!resetn_in)
      chan_r[0] == chan_r[1] |=> mis_cnt_r == 16'h0000)
      else $error("Discrepancy timer kept running while channels agree.");

   a_run_needs_both: assert property (@(posedge clk_in) disable iff (!resetn_in)
      run_enable_out |-> $past(chan_r) == 2'b11)
      else $error("Run enabled without both channels high.");

   a_log_when_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !start_cmd_in && !running_in |=> !trip_log_out)
      else $error("Trip logged while stopped.");

endmodule : torque_off_monitor

// [core/torque_off_pkg.sv]
package torque_off_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned TICK_US = 100;
   localparam int unsigned TICK_DIV = CLK_HZ / 1000000 * TICK_US;
   localparam int unsigned PULSE_REJECT_US = 2000;
   localparam int unsigned QUALIFY_US = 6000;
   localparam int unsigned MISMATCH_OK_MS = 1600;
   localparam int unsigned MISMATCH_FAULT_MS = 3000;
   localparam int unsigned FAULT_PICK_MS = 2300;
   localparam int unsigned QUALIFY_TICKS = QUALIFY_US / TICK_US;
   localparam int unsigned FAULT_TICKS = FAULT_PICK_MS * 1000 / TICK_US;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_SAFE = 2'b00,
      ST_RUN_OK = 2'b01,
      ST_MISMATCH = 2'b10,
      ST_LOCKED = 2'b11
   } monitor_state_t;

endpackage : torque_off_pkg

// [verif/safety_relay_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far side relays
// ----------------------------------------------------------------
module safety_relay_model #(
   parameter int unsigned PULSE_CYC = 37500
) (
   input wire logic clk_in,
   input wire logic level_a_in,
   input wire logic level_b_in,
   input wire logic pulse_a_in,
   output logic channel_a_out,
   output logic channel_b_out
);
   // Test pulses last 1.5 ms of monitor time, inside the 2 ms that it must ignore.
   int unsigned pulse_cnt_r = 0;
   always @(posedge clk_in) begin
      if (pulse_a_in && pulse_cnt_r == 0) pulse_cnt_r <= PULSE_CYC;
      else if (pulse_cnt_r != 0) pulse_cnt_r <= pulse_cnt_r - 1;
      channel_a_out <= level_a_in && (pulse_cnt_r == 0);
      channel_b_out <= level_b_in;
   end
endmodule : safety_relay_model

// [verif/test_dual_channel_torque_off_monitor.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module test_dual_channel_torque_off_monitor;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic level_a = 1'b0;
   logic level_b = 1'b0;
   logic pulse_a = 1'b0;
   logic start_cmd = 1'b1;
   logic running = 1'b0;
   logic ch_a;
   logic ch_b;
   logic run_en, trip, ind, locked, tlog;
   logic [4:0] outs;
   int fail_count = 0;
   int cmp_count = 0;
   assign outs = {run_en, trip, ind, locked, tlog};

   // The tick is cut to two clocks so that a full fault time fits the run.
   // Every rule time counts ticks, so 1 ms of rule time is 20 clocks here.
   safety_relay_model #(.PULSE_CYC(30)) relays (.clk_in(clk_in), .level_a_in(level_a), .level_b_in(level_b),
      .pulse_a_in(pulse_a), .channel_a_out(ch_a), .channel_b_out(ch_b));
   torque_off_monitor #(.TICK_DIV_P(2)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .safety_enable_channel_a_in(ch_a), .safety_enable_channel_b_in(ch_b),
      .start_cmd_in(start_cmd), .running_in(running),
      .run_enable_out(run_en), .torque_off_trip_out(trip), .safe_state_indicator_out(ind),
      .fault_locked_out(locked), .trip_log_out(tlog));

   initial begin
      forever #20 clk_in = ~clk_in;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask : cyc

   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up();
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic t_safe();
      cyc(12);
      chk(outs, 5'h0d);
      @(posedge clk_in) start_cmd <= 1'b0;
      cyc(5);
      chk(outs, 5'h0c);
   endtask : t_safe

   task automatic t_one_channel();
      @(posedge clk_in) level_a <= 1'b1;
      cyc(10);
      chk(outs, 5'h08);
      cyc(20000);
      chk(outs, 5'h08);
   endtask : t_one_channel

   task automatic t_run();
      @(posedge clk_in) level_b <= 1'b1;
      cyc(10);
      chk(outs, 5'h10);
   endtask : t_run

   task automatic t_pulse();
      @(posedge clk_in) pulse_a <= 1'b1;
      @(posedge clk_in) pulse_a <= 1'b0;
      repeat (300) begin
         @(negedge clk_in);
         chk(outs, 5'h10);
      end
   endtask : t_pulse

   task automatic t_fall();
      int hits;
      hits = 0;
      @(posedge clk_in) begin
         running <= 1'b1;
         level_a <= 1'b0;
         level_b <= 1'b0;
      end
      for (int i = 1; i <= 200; i++) begin
         @(negedge clk_in);
         if (tlog === 1'b1) hits++;
         if (i == 40) chk(outs, 5'h10);
         if (i == 100) chk(outs, 5'h10);
      end
      chk(outs, 5'h0c);
      chk(5'(hits), 5'h01);
      @(posedge clk_in) running <= 1'b0;
   endtask : t_fall

   task automatic t_lock();
      @(posedge clk_in) level_a <= 1'b1;
      cyc(32000);
      chk(outs, 5'h08);
      cyc(28000);
      chk(outs, 5'h0a);
      @(posedge clk_in) level_b <= 1'b1;
      cyc(10);
      chk(outs, 5'h0a);
      @(posedge clk_in) begin
         level_a <= 1'b0;
         level_b <= 1'b0;
      end
      cyc(200);
      chk(outs, 5'h0a);
   endtask : t_lock

   task automatic t_reset();
      @(posedge clk_in) begin
         level_a <= 1'b1;
         level_b <= 1'b1;
      end
      @(posedge clk_in) resetn_in <= 1'b0;
      cyc(2);
      chk(outs, 5'h08);
      @(posedge clk_in) resetn_in <= 1'b1;
      cyc(12);
      chk(outs, 5'h10);
   endtask : t_reset

   initial begin
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      t_safe();
      t_one_channel();
      t_run();
      t_pulse();
      t_fall();
      t_lock();
      t_reset();
      wrap_up();
   end

   initial begin
      #3600000;
      fail_count++;
      wrap_up();
   end
endmodule : test_dual_channel_torque_off_monitor
